/* File: hw/ovfr_params.svh */
// constants for the output voltage fault response block
`ifndef OVFR_PARAMS_SVH
`define OVFR_PARAMS_SVH
`define OVFR_NCH 8
`define OVFR_ACT_HI 7
`define OVFR_ACT_LO 6
`define OVFR_RTY_HI 5
`define OVFR_RTY_LO 3
`define OVFR_DLY_HI 2
`define OVFR_DLY_LO 0
`define OVFR_ACT_IGNORE 2'h0
`define OVFR_ACT_DEGLITCH 2'h1
`define OVFR_RTY_NONE 3'h0
`define OVFR_DLY_NONE 3'h0
`define OVFR_POLICY_RST 8'h00
`define OVFR_SAMPLE_NS 12200
`define OVFR_CLK_NS 100
`define OVFR_SAMPLE_CYC ((`OVFR_SAMPLE_NS + `OVFR_CLK_NS - 1) / `OVFR_CLK_NS)
`define OVFR_SB_VOUT 5
`define OVFR_SW_VOUT 15
`define OVFR_SV_OV 7
`define OVFR_SV_UV 4
`endif

/* File: hw/ovfr_pkg.sv */
// types for the output voltage fault response block
package ovfr_pkg;
    typedef enum logic [3:0] {
        OVFR_RUN = 4'h1,
        OVFR_WAIT = 4'h2,
        OVFR_OFF = 4'h4,
        OVFR_HOLD = 4'h8
    } ovfr_state_t;
    typedef struct packed {
        logic [1:0] action;
        logic [2:0] restart;
        logic [2:0] deglitch;
    } ovfr_policy_t;
    typedef struct packed {
        logic [7:0] status_byte;
        logic [15:0] status_word;
        logic [7:0] status_vout;
    } ovfr_status_t;
endpackage

/* File: hw/ovfr_chan.sv */
// one channel: deglitch, shutdown and restart sequencing for one fault type
`timescale 1ns/10ps
`include "ovfr_params.svh"
module ovfr_chan
    import ovfr_pkg::*;
(
    // clock and reset
    input wire logic sys_clk,
    input wire logic srst,
    // settings
    input wire ovfr_pkg::ovfr_policy_t policy,
    input wire logic [2:0] retry_limit,
    // events
    input wire logic sample_tick,
    input wire logic fault,
    input wire logic stop_retry,
    input wire logic other_shutdown,
    input wire logic clear_fault,
    input wire logic restart_done,
    // results
    output logic shutdown,
    output logic fault_event
);
    typedef struct packed {
        ovfr_state_t st;
        logic [2:0] cnt;
        logic [2:0] tries;
        logic shutdown;
        logic fault_event;
        logic fault_d;
    } ovfr_chan_st_t;
    ovfr_chan_st_t r, next_r;

    always_comb
    begin
        next_r = r;
        next_r.fault_event = fault && !r.fault_d;
        next_r.fault_d = fault;
        case (r.st)
            OVFR_RUN:
            begin
                next_r.shutdown = 1'b0;
                if (fault && policy.action != `OVFR_ACT_IGNORE)
                begin
                    if (policy.action == `OVFR_ACT_DEGLITCH
                        && policy.deglitch != `OVFR_DLY_NONE)
                    begin
                        next_r.st = OVFR_WAIT;
                        next_r.cnt = 3'h0;
                    end
                    else
                    begin
                        next_r.st = OVFR_OFF;
                        next_r.shutdown = 1'b1;
                    end
                end
            end
            OVFR_WAIT:
            begin
                if (!fault)
                    next_r.st = OVFR_RUN; // glitch filtered
                else if (sample_tick)
                begin
                    next_r.cnt = r.cnt + 3'h1;
                    if (r.cnt + 3'h1 == policy.deglitch)
                    begin
                        next_r.st = OVFR_OFF;
                        next_r.shutdown = 1'b1;
                    end
                end
            end
            OVFR_OFF:
            begin
                // decide restart once off
                if (policy.restart == `OVFR_RTY_NONE || stop_retry
                    || other_shutdown || r.tries >= retry_limit)
                    next_r.st = OVFR_HOLD;
                else if (restart_done && !fault)
                begin
                    next_r.tries = r.tries + 3'h1;
                    next_r.st = OVFR_RUN;
                    next_r.shutdown = 1'b0;
                end
            end
            OVFR_HOLD:
            begin
                if (clear_fault)
                begin
                    next_r.st = OVFR_RUN;
                    next_r.tries = 3'h0;
                    next_r.shutdown = 1'b0;
                end
            end
            default:
            begin
                next_r.st = OVFR_RUN;
            end
        endcase
    end

    always_ff @(posedge sys_clk)
    begin
        if (srst)
        begin
            r <= '{st: OVFR_RUN, cnt: 3'h0, tries: 3'h0, shutdown: 1'b0,
                   fault_event: 1'b0, fault_d: 1'b0};
        end
        else
        begin
            r <= next_r;
        end
    end

    assign shutdown = r.shutdown;
    assign fault_event = r.fault_event;

    a_ignore_no_off: assert property (@(posedge sys_clk) disable iff (srst)
        r.st == OVFR_RUN && policy.action == `OVFR_ACT_IGNORE |=> !r.shutdown)
        else $error("ignore action shut channel down");
    a_immediate_off: assert property (@(posedge sys_clk) disable iff (srst)
        r.st == OVFR_RUN && fault && policy.action[1] |=> r.shutdown)
        else $error("immediate action did not shut down");
    a_hold_no_retry: assert property (@(posedge sys_clk) disable iff (srst)
        r.st == OVFR_HOLD && !clear_fault |=> r.st == OVFR_HOLD && r.shutdown)
        else $error("held channel restarted");
endmodule // ovfr_chan

/* File: hw/ovfr_top.sv */
// output voltage fault response for eight channels, ov and uv
`timescale 1ns/10ps
`include "ovfr_params.svh"
// Notes on behaviour
// - action 00b: record fault, channel keeps running
// - action 01b: wait deglitch samples, shut down if fault persists
// - action 1Xb: shut down, immediate or sequenced per shutdown style
// - after fault shutdown, restart decision uses the restart field
// - restart 000b: no restart, output stays off until fault cleared
// - nonzero restart: retry to global limit unless commanded off, bias lost or other fault
// - deglitch field counts samples a fault must persist before shutdown
// - deglitch 000b: shut down with no wait
// - nonzero deglitch: off after that many consecutive 12.2 us samples
// - each fault sets status byte, status word and vout status bits
// - each fault pulls the host alert line low
// - odd channels in current mode ignore ov/uv faults
// - responses driven only by fast supervisor measurements
// - sequenced turn-off delay timed by shared clock else internal oscillator
module ovfr_top
    import ovfr_pkg::*;
(
    // clock and reset
    input wire logic sys_clk,
    input wire logic srst,
    // policy bytes per channel
    input wire logic [`OVFR_NCH*8-1:0] overvoltage_fault_policy,
    input wire logic [`OVFR_NCH*8-1:0] undervoltage_fault_policy,
    input wire logic [2:0] retry_limit,
    input wire logic [`OVFR_NCH-1:0] seq_off_style,
    input wire logic [`OVFR_NCH-1:0] current_mode,
    // fast supervisor comparator results
    input wire logic [`OVFR_NCH-1:0] sup_ov,
    input wire logic [`OVFR_NCH-1:0] sup_uv,
    // off delay timebase
    input wire logic share_clk_present,
    input wire logic share_tick,
    input wire logic osc_tick,
    input wire logic [15:0] off_delay_ticks,
    // control
    input wire logic [`OVFR_NCH-1:0] commanded_off,
    input wire logic bias_lost,
    input wire logic clear_faults,
    input wire logic [`OVFR_NCH-1:0] restart_done,
    // outputs
    output logic [`OVFR_NCH-1:0] chan_enable,
    output ovfr_pkg::ovfr_status_t [`OVFR_NCH-1:0] status,
    output logic host_alert_line_o,
    output logic host_alert_line_oe
);
    function automatic logic chan_masked(input int idx, input logic cm);
        chan_masked = (idx % 2 == 1) && cm;
    endfunction

    typedef struct packed {
        logic [7:0] tick_cnt;
        logic sample_tick;
        logic [`OVFR_NCH-1:0] chan_enable;
        logic [`OVFR_NCH-1:0] off_pend;
        logic [`OVFR_NCH-1:0][15:0] off_cnt;
        ovfr_status_t [`OVFR_NCH-1:0] status;
        logic alert;
    } ovfr_top_st_t;
    ovfr_top_st_t r, next_r;

    logic [`OVFR_NCH-1:0] ov_sd, uv_sd, ov_ev, uv_ev, ov_f, uv_f;
    logic off_tick;
    assign off_tick = share_clk_present ? share_tick : osc_tick;

    genvar g;
    generate
        for (g = 0; g < `OVFR_NCH; g++)
        begin : g_ch
            assign ov_f[g] = sup_ov[g] && !chan_masked(g, current_mode[g]);
            assign uv_f[g] = sup_uv[g] && !chan_masked(g, current_mode[g]);
            ovfr_chan u_ov (
                .sys_clk(sys_clk), .srst(srst),
                .policy(ovfr_policy_t'(overvoltage_fault_policy[g*8 +: 8])),
                .retry_limit(retry_limit), .sample_tick(r.sample_tick),
                .fault(ov_f[g]), .stop_retry(commanded_off[g] || bias_lost),
                .other_shutdown(uv_sd[g]), .clear_fault(clear_faults),
                .restart_done(restart_done[g]), .shutdown(ov_sd[g]), .fault_event(ov_ev[g]));
            ovfr_chan u_uv (
                .sys_clk(sys_clk), .srst(srst),
                .policy(ovfr_policy_t'(undervoltage_fault_policy[g*8 +: 8])),
                .retry_limit(retry_limit), .sample_tick(r.sample_tick),
                .fault(uv_f[g]), .stop_retry(commanded_off[g] || bias_lost),
                .other_shutdown(ov_sd[g]), .clear_fault(clear_faults),
                .restart_done(restart_done[g]), .shutdown(uv_sd[g]), .fault_event(uv_ev[g]));
        end
    endgenerate

    always_comb
    begin
        next_r = r;
        next_r.sample_tick = 1'b0;
        if (r.tick_cnt == 8'(`OVFR_SAMPLE_CYC - 1))
        begin
            next_r.tick_cnt = 8'h00;
            next_r.sample_tick = 1'b1;
        end
        else
            next_r.tick_cnt = r.tick_cnt + 8'h01;
        if (clear_faults)
            next_r.alert = 1'b0;
        for (int i = 0; i < `OVFR_NCH; i++)
        begin
            if (clear_faults)
                next_r.status[i] = '0;
            if (ov_ev[i] || uv_ev[i]) // set wins over clear
            begin
                next_r.status[i].status_byte[`OVFR_SB_VOUT] = 1'b1;
                next_r.status[i].status_word[`OVFR_SW_VOUT] = 1'b1;
                next_r.alert = 1'b1;
            end
            if (ov_ev[i])
                next_r.status[i].status_vout[`OVFR_SV_OV] = 1'b1;
            if (uv_ev[i])
                next_r.status[i].status_vout[`OVFR_SV_UV] = 1'b1;
            if (!(ov_sd[i] || uv_sd[i]))
            begin
                next_r.chan_enable[i] = 1'b1;
                next_r.off_pend[i] = 1'b0;
                next_r.off_cnt[i] = 16'h0000;
            end
            else if (!seq_off_style[i])
                next_r.chan_enable[i] = 1'b0;
            else if (r.chan_enable[i])
            begin
                next_r.off_pend[i] = 1'b1;
                if (off_tick)
                    next_r.off_cnt[i] = r.off_cnt[i] + 16'h0001;
                if (r.off_cnt[i] >= off_delay_ticks)
                    next_r.chan_enable[i] = 1'b0;
            end
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (srst)
        begin
            r <= '0;
        end
        else
        begin
            r <= next_r;
        end
    end

    assign chan_enable = r.chan_enable;
    assign status = r.status;
    assign host_alert_line_o = 1'b0;
    assign host_alert_line_oe = r.alert;

    a_alert_on_fault: assert property (@(posedge sys_clk) disable iff (srst)
        (ov_ev[0] || uv_ev[0]) |=> host_alert_line_oe)
        else $error("alert not raised on fault");
    a_status_on_ov: assert property (@(posedge sys_clk) disable iff (srst)
        ov_ev[0] |=> status[0].status_vout[`OVFR_SV_OV])
        else $error("ov status bit not set");
    a_masked_odd: assert property (@(posedge sys_clk) disable iff (srst)
        current_mode[1] |-> !ov_f[1] && !uv_f[1])
        else $error("masked channel responded");
    a_tick_period: assert property (@(posedge sys_clk) disable iff (srst)
        r.sample_tick |=> !r.sample_tick [*8])
        else $error("sample tick too frequent");
    a_immediate_off: assert property (@(posedge sys_clk) disable iff (srst)
        ov_sd[0] && !seq_off_style[0] |=> !chan_enable[0])
        else $error("immediate shutdown did not disable");

    // channel 0 stands for every channel in the checks below, channel 1 for the masked odd channels
    sequence s_chan0_down;
        ov_sd[0] || uv_sd[0];
    endsequence

    sequence s_seq_running;
        seq_off_style[0] && chan_enable[0];
    endsequence

    sequence s_seq_expired;
        seq_off_style[0] && chan_enable[0] && r.off_cnt[0] >= off_delay_ticks;
    endsequence

    a_seq_pending: assert property (@(posedge sys_clk) disable iff (srst)
        s_chan0_down ##0 s_seq_running |=> r.off_pend[0])
        else $error("sequenced turn-off not pending");

    a_seq_expiry: assert property (@(posedge sys_clk) disable iff (srst)
        s_chan0_down ##0 s_seq_expired |=> !chan_enable[0])
        else $error("sequenced turn-off did not disable");

    a_resume_enable: assert property (@(posedge sys_clk) disable iff (srst)
        !(ov_sd[0] || uv_sd[0]) |=> chan_enable[0])
        else $error("channel not running without shutdown");

    a_status_on_uv: assert property (@(posedge sys_clk) disable iff (srst)
        uv_ev[0] |=> status[0].status_vout[`OVFR_SV_UV])
        else $error("uv status bit not set");

    a_status_summary: assert property (@(posedge sys_clk) disable iff (srst)
        (ov_ev[0] || uv_ev[0])
        |=> status[0].status_byte[`OVFR_SB_VOUT] && status[0].status_word[`OVFR_SW_VOUT])
        else $error("summary status bits not set");

    a_alert_holds: assert property (@(posedge sys_clk) disable iff (srst)
        host_alert_line_oe && !clear_faults |=> host_alert_line_oe)
        else $error("alert released without clear");

    a_masked_event: assert property (@(posedge sys_clk) disable iff (srst)
        current_mode[1] |=> !ov_ev[1] && !uv_ev[1])
        else $error("masked channel raised a fault event");

    a_tick_rate: assert property (@(posedge sys_clk) disable iff (srst)
        r.tick_cnt == 8'(`OVFR_SAMPLE_CYC - 1) |=> r.sample_tick)
        else $error("sample tick missing");

    a_clear_status: assert property (@(posedge sys_clk) disable iff (srst)
        clear_faults && !ov_ev[0] && !uv_ev[0] |=> status[0] == '0)
        else $error("status not cleared");
endmodule // ovfr_top

/* File: tb/ovfr_conv_model.sv */
// converter side model: restart readiness and alert pull-up
`timescale 1ns/10ps
module ovfr_conv_model
(
    // clock and reset
    input wire logic sys_clk,
    input wire logic srst,
    // from the block
    input wire logic [7:0] chan_enable,
    input wire logic alert_o,
    input wire logic alert_oe,
    // to the block
    output logic [7:0] restart_done,
    output wire logic alert_wire
);
    logic [4:0] cnt [8] = '{default: 5'h00};
    logic [7:0] pulse = 8'h00;
    // open-drain alert line with pull-up
    assign alert_wire = alert_oe ? alert_o : 1'b1;
    assign restart_done = pulse;
    // a disabled converter reports ready 16 cycles after it is disabled, then every 32 cycles
    always @(posedge sys_clk)
    begin
        for (int i = 0; i < 8; i++)
        begin
            cnt[i] <= (srst || chan_enable[i]) ? 5'h00 : cnt[i] + 5'h01;
            pulse[i] <= !srst && !chan_enable[i] && cnt[i] == 5'h0F;
        end
    end
endmodule // ovfr_conv_model

/* File: tb/tb.sv */
// randomised bench for the voltage fault response block
`timescale 1ns/10ps
`include "ovfr_params.svh"
module tb;
    import ovfr_pkg::*;
    localparam int S = `OVFR_SAMPLE_CYC;
    logic sys_clk = 1'b0;
    logic srst = 1'b1;
    logic [63:0] ovp = 64'h0;
    logic [63:0] uvp = 64'h0;
    logic [2:0] rlim = 3'h7;
    logic [7:0] seq = 8'h00, cmode = 8'h00, sov = 8'h00, suv = 8'h00, coff = 8'h00;
    logic shp = 1'b0, sht = 1'b0, ost = 1'b0, bias = 1'b0, clr = 1'b0;
    logic [15:0] dly = 16'h0000;
    logic [7:0] rdone, en, pol;
    ovfr_status_t [7:0] st;
    logic ao, aoe, alert;
    int num_errors = 0, cmp_count = 0, cyc = 0, ch = 0;
    initial forever #50 sys_clk = ~sys_clk;
    ovfr_top dut (.sys_clk(sys_clk), .srst(srst), .overvoltage_fault_policy(ovp),
        .undervoltage_fault_policy(uvp), .retry_limit(rlim), .seq_off_style(seq),
        .current_mode(cmode), .sup_ov(sov), .sup_uv(suv), .share_clk_present(shp),
        .share_tick(sht), .osc_tick(ost), .off_delay_ticks(dly), .commanded_off(coff),
        .bias_lost(bias), .clear_faults(clr), .restart_done(rdone), .chan_enable(en),
        .status(st), .host_alert_line_o(ao), .host_alert_line_oe(aoe));
    ovfr_conv_model conv (.sys_clk(sys_clk), .srst(srst), .chan_enable(en), .alert_o(ao),
        .alert_oe(aoe), .restart_done(rdone), .alert_wire(alert));
    task automatic print_verdict();
        if (num_errors == 0 && cmp_count > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    // cut a hung run short
    always @(posedge sys_clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 60000)
        begin
            num_errors = num_errors + 1;
            print_verdict();
        end
    end
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp)
        begin
            num_errors++;
            $display("ERROR %s expected %0h seen %0h", what, exp, seen);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
    endtask
    // status byte, status word and vout bits of one fault type
    function automatic logic [2:0] fbits(input int c, input bit ov);
        return {st[c].status_byte[`OVFR_SB_VOUT], st[c].status_word[`OVFR_SW_VOUT],
            st[c].status_vout[ov ? `OVFR_SV_OV : `OVFR_SV_UV]};
    endfunction
    task automatic hit(input bit ov, input bit v);
        if (ov)
            sov[ch] <= v;
        else
            suv[ch] <= v;
    endtask
    // reset with one policy for the faulting type and another for the other type
    task automatic start(input bit ov, input logic [7:0] same, input logic [7:0] other);
        srst <= 1'b1;
        {sov, suv, coff, cmode, seq, shp, sht, ost, bias, clr} <= '0;
        ovp <= {8{ov ? same : other}};
        uvp <= {8{ov ? other : same}};
        rlim <= 3'($urandom_range(7, 1));
        ch = $urandom % 8;
        tick(16);
        srst <= 1'b0;
        tick(3);
        chk("enable", en[ch], 1'b1);
        chk("status", st[ch], 32'h0);
    endtask
    initial
    begin
        void'($urandom(11125));
        // every action code, both fault types, no deglitch
        for (int i = 0; i < 8; i++)
        begin
            pol = {i[2:1], 6'($urandom) & 6'h38};
            start(i[0], pol, 8'hC0);
            hit(i[0], 1'b1);
            tick(5);
            chk("enable", en[ch], pol[7:6] == 2'h0);
            chk("status", fbits(ch, i[0]), 3'h7);
            chk("alert", alert, 1'b0);
        end
        // odd channel in current mode
        start(1, 8'hC0, 8'hC0);
        ch = ch | 1;
        cmode[ch] <= 1'b1;
        tick(1);
        hit(1, 1'b1);
        tick(6);
        chk("masked enable", en[ch], 1'b1);
        chk("masked status", st[ch], 32'h0);
        chk("masked alert", alert, 1'b1);
        // deglitch counts at every nonzero value
        for (int n = 1; n < 8; n++)
        begin
            start(1, 8'h40 | 8'(n), 8'h00);
            hit(1, 1'b1);
            if (n > 1)
            begin
                tick((n - 1) * S - 3);
                chk("deglitch enable", en[ch], 1'b1);
            end
            tick(n > 1 ? S + 8 : S + 5);
            chk("deglitch enable", en[ch], 1'b0);
        end
        // glitch shorter than the deglitch count
        start(0, 8'h43, 8'h00);
        hit(0, 1'b1);
        tick(S);
        hit(0, 1'b0);
        tick(4 * S);
        chk("glitch enable", en[ch], 1'b1);
        // restart policy: none, retry, retry stopped by command or bias
        for (int k = 0; k < 4; k++)
        begin
            start(1, {2'h2, k == 0 ? 3'h0 : 3'($urandom_range(7, 1)), 3'h0}, 8'h00);
            hit(1, 1'b1);
            tick(5);
            hit(1, 1'b0);
            if (k == 2)
                coff[ch] <= 1'b1;
            if (k == 3)
                bias <= 1'b1;
            tick(40);
            chk("restart enable", en[ch], k == 1);
            if (k == 0)
            begin
                clr <= 1'b1;
                tick(1);
                clr <= 1'b0;
                tick(5);
                chk("cleared status", st[ch], 32'h0);
                chk("cleared alert", alert, 1'b1);
                chk("cleared enable", en[ch], 1'b1);
            end
        end
        // sequenced turn-off on the internal oscillator, then on the shared clock
        for (int sh = 0; sh < 2; sh++)
        begin
            start(1, 8'hC0, 8'h00);
            dly <= 16'($urandom_range(60, 20));
            seq[ch] <= 1'b1;
            shp <= sh[0];
            sht <= sh[0];
            ost <= !sh[0];
            tick(2);
            hit(1, 1'b1);
            tick(dly - 4);
            chk("seq enable", en[ch], 1'b1);
            tick(12);
            chk("seq enable", en[ch], 1'b0);
        end
        print_verdict();
    end
endmodule // tb
